// >>> svm_supply_level_monitor.v
// Operation
// RQ1 - seven inputs: five rails and two current senses, slots zero to six
// RQ2 - only domains with their enable bit set are sampled
// RQ3 - each enabled domain gets a new level once per superframe
// RQ4 - enabled domain interrupts when level below lower or above upper
// RQ5 - host writes one to page select before touching monitor registers
// RQ6 - reset sets every lower threshold 0x00 and upper 0xFF
// RQ7 - interrupt enable ignored while the domain measure enable is zero
// RQ8 - level and both flags update together when sampling completes
// RQ9 - below flag set when level is less than lower threshold
// RQ10 - above flag set when level exceeds upper threshold
// RQ11 - level of a disabled domain reads zero
// RQ12 - flags clear only by writing one; host clears serviced bits
// RQ13 - codes unsigned 8-bit, 0x00 bottom to 0xFF top of range
// RQ14 - enable bits order: input, bus, io, transceiver, core, low, high
// RQ15 - irq is OR of (flag and irq enable and measure enable)
`timescale 1ns/1ps
`default_nettype none
`include "svm_map.vh"
// ==========================================
// top: apb slave, superframe timer, converter sequencer
module svm_supply_level_monitor #(
	parameter FRAME_CYC = `SVM_FRAME_CYC
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// converter port
	output reg conv_start,
	output reg [2:0] conv_channel,
	input wire conv_done,
	input wire [7:0] conv_code,
	// monitor interrupt request
	output wire monitor_irq
);
	localparam N = `SVM_NUM_DOM;
	// sequencer states
	localparam S_IDLE = 2'd0;
	localparam S_CONV = 2'd1;
	localparam S_NEXT = 2'd2;

	reg [6:0] domain_measure_enable_q;
	reg [6:0] domain_irq_enable_q;
	reg [7:0] register_page_select_q;
	reg [31:0] frame_cnt_q;
	reg frame_stb_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [2:0] chan_d;
	reg start_d;
	reg [31:0] rdata_d;
	reg hit_d;
	wire access;
	wire wr;
	wire page_ok;
	wire [N*8-1:0] level_bus;
	wire [N*8-1:0] lower_bus;
	wire [N*8-1:0] upper_bus;
	wire [N-1:0] below_flags;
	wire [N-1:0] above_flags;
	wire [N-1:0] samp_stb;
	integer i;
	// per-register selects, shared by the write paths
	wire sel_page;
	wire sel_enable;
	wire sel_irq_en;
	wire sel_below;
	wire sel_above;
	// per-domain strobes, one bit per slot
	wire [N-1:0] lower_we;
	wire [N-1:0] upper_we;
	wire [N-1:0] below_clr;
	wire [N-1:0] above_clr;
	// enabled sources of the request, before the final or
	wire [N-1:0] irq_src;

	// ==========================================
	// apb: zero wait states, error on unmapped or wrong page
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign pready = 1'b1;
	assign pslverr = access & ~hit_d;
	// monitor registers only answer on page one; page select always does
	assign page_ok = (register_page_select_q == `SVM_MON_PAGE); // [RQ5]

	// fixed register selects; monitor ones need page one as well
	assign sel_page = (paddr == `SVM_OFF_PAGE);
	assign sel_enable = page_ok & (paddr == `SVM_OFF_ENABLE);
	assign sel_irq_en = page_ok & (paddr == `SVM_OFF_IRQ_EN);
	assign sel_below = page_ok & (paddr == `SVM_OFF_BELOW);
	assign sel_above = page_ok & (paddr == `SVM_OFF_ABOVE);

	// decode and read mux
	always @* begin
		rdata_d = 32'h0;
		hit_d = 1'b0;
		if (paddr == `SVM_OFF_PAGE) begin
			hit_d = 1'b1;
			rdata_d = {24'h0, register_page_select_q};
		end else if (page_ok) begin
			case (paddr)
			`SVM_OFF_ENABLE: begin
				hit_d = 1'b1;
				rdata_d = {25'h0, domain_measure_enable_q};
			end
			`SVM_OFF_IRQ_EN: begin
				hit_d = 1'b1;
				rdata_d = {25'h0, domain_irq_enable_q};
			end
			`SVM_OFF_BELOW: begin
				hit_d = 1'b1;
				rdata_d = {25'h0, below_flags};
			end
			`SVM_OFF_ABOVE: begin
				hit_d = 1'b1;
				rdata_d = {25'h0, above_flags};
			end
			default: begin
				for (i = 0; i < N; i = i + 1) begin
					if (paddr == `SVM_OFF_LEVEL0 + 4 * i) begin
						hit_d = 1'b1;
						rdata_d = {24'h0, level_bus[i*8 +: 8]};
					end
					if (paddr == `SVM_OFF_LOWER0 + 4 * i) begin
						hit_d = 1'b1;
						rdata_d = {24'h0, lower_bus[i*8 +: 8]};
					end
					if (paddr == `SVM_OFF_UPPER0 + 4 * i) begin
						hit_d = 1'b1;
						rdata_d = {24'h0, upper_bus[i*8 +: 8]};
					end
				end
			end
			endcase
		end
	end

	// read data registered in the setup cycle, so it already stands at
	// the access edge where the master takes it; the word is one cycle
	// older than that edge, which keeps zero wait states
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			prdata <= 32'h0;
		else if (psel & ~penable & ~pwrite)
			prdata <= rdata_d;
	end

	// page select answers on any page, so software can always get back
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			register_page_select_q <= 8'h00;
		else if (wr & sel_page)
			register_page_select_q <= pwdata[7:0]; // [RQ5]
	end

	// measure enables, bit n is slot n
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			domain_measure_enable_q <= 7'h00;
		else if (wr & sel_enable)
			domain_measure_enable_q <= pwdata[6:0]; // [RQ14]
	end

	// interrupt enables; they only count with the measure enable set
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			domain_irq_enable_q <= 7'h00;
		else if (wr & sel_irq_en)
			domain_irq_enable_q <= pwdata[6:0]; // [RQ4]
	end

	// ==========================================
	// superframe tick
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_cnt_q <= 32'h0;
			frame_stb_q <= 1'b0;
		end else if (frame_cnt_q >= FRAME_CYC - 1) begin
			frame_cnt_q <= 32'h0;
			frame_stb_q <= 1'b1;
		end else begin
			frame_cnt_q <= frame_cnt_q + 32'h1;
			frame_stb_q <= 1'b0;
		end
	end

	// ==========================================
	// sequencer: one conversion per enabled slot per superframe
	// a frame tick while busy is dropped; conversions must fit a frame
	// per slot: one cycle in S_NEXT, then S_CONV until conv_done;
	// a disabled slot costs one S_NEXT cycle and starts nothing.
	// a slow converter that overruns the frame makes some enabled
	// domains miss their update for that frame
	always @* begin
		state_d = state_q;
		chan_d = conv_channel;
		start_d = 1'b0;
		case (state_q)
		S_IDLE: begin
			if (frame_stb_q) begin
				chan_d = 3'd0;
				state_d = S_NEXT;
			end
		end
		S_NEXT: begin
			if (conv_channel == N[2:0]) begin
				state_d = S_IDLE;
			end else if (domain_measure_enable_q[conv_channel]) begin // [RQ2]
				start_d = 1'b1;
				state_d = S_CONV;
			end else begin
				chan_d = conv_channel + 3'd1;
			end
		end
		S_CONV: begin
			if (conv_done) begin
				chan_d = conv_channel + 3'd1;
				state_d = S_NEXT;
			end
		end
		default: state_d = S_IDLE;
		endcase
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			conv_channel <= 3'd0;
			conv_start <= 1'b0;
		end else begin
			state_q <= state_d;
			conv_channel <= chan_d;
			conv_start <= start_d;
		end
	end

	// ==========================================
	// per-domain slots, indexed by converter channel
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : dom // [RQ1]
			assign samp_stb[g] = (state_q == S_CONV) & conv_done &
				(conv_channel == g); // [RQ3]
			// write strobes for this slot; a clear needs its own data bit
			assign lower_we[g] = wr & page_ok &
				(paddr == `SVM_OFF_LOWER0 + 4 * g);
			assign upper_we[g] = wr & page_ok &
				(paddr == `SVM_OFF_UPPER0 + 4 * g);
			assign below_clr[g] = wr & sel_below & pwdata[g]; // [RQ12]
			assign above_clr[g] = wr & sel_above & pwdata[g]; // [RQ12]
			svm_domain u_dom (
				.clock(clock),
				.rst_n(rst_n),
				.sample_stb(samp_stb[g]),
				.sample_code(conv_code),
				.measure_en(domain_measure_enable_q[g]),
				.lower_we(lower_we[g]),
				.upper_we(upper_we[g]),
				.wdata(pwdata[7:0]),
				.below_clr(below_clr[g]),
				.above_clr(above_clr[g]),
				.level(level_bus[g*8 +: 8]),
				.lower_q(lower_bus[g*8 +: 8]),
				.upper_q(upper_bus[g*8 +: 8]),
				.below_q(below_flags[g]),
				.above_q(above_flags[g])
			);
		end
	endgenerate

	// ==========================================
	// irq level holds until flags, irq enables or measure enables cleared; a flag on a domain whose
	// measure enable is off stays stored but is kept out of the request
	assign irq_src = (below_flags | above_flags) &
		domain_irq_enable_q & domain_measure_enable_q; // [RQ7] [RQ15]
	assign monitor_irq = |irq_src; // [RQ4]
endmodule // svm_supply_level_monitor
`default_nettype wire

// >>> svm_map.vh
`ifndef SVM_MAP_VH
`define SVM_MAP_VH
// ==========================================
// register byte offsets
`define SVM_OFF_ENABLE 12'h000
`define SVM_OFF_IRQ_EN 12'h004
`define SVM_OFF_BELOW 12'h008
`define SVM_OFF_ABOVE 12'h00C
`define SVM_OFF_PAGE 12'h010
`define SVM_OFF_LEVEL0 12'h040
`define SVM_OFF_LOWER0 12'h060
`define SVM_OFF_UPPER0 12'h080
// ==========================================
// reset values and constants
`define SVM_LOWER_RST 8'h00
`define SVM_UPPER_RST 8'hFF
`define SVM_LEVEL_OFF 8'h00
`define SVM_MON_PAGE 8'h01
`define SVM_NUM_DOM 7
// superframe period in ns (48 kHz frame)
`define SVM_FRAME_NS 20833
`define SVM_CLK_NS 8
`define SVM_FRAME_CYC (`SVM_FRAME_NS / `SVM_CLK_NS)
`endif

// >>> svm_domain.v
`timescale 1ns/1ps
`default_nettype none
`include "svm_map.vh"
// ==========================================
// one monitored domain: level, thresholds, sticky flags
module svm_domain (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// sample in
	input wire sample_stb,
	input wire [7:0] sample_code,
	input wire measure_en,
	// threshold writes
	input wire lower_we,
	input wire upper_we,
	input wire [7:0] wdata,
	// flag clears
	input wire below_clr,
	input wire above_clr,
	// state out
	output wire [7:0] level,
	output reg [7:0] lower_q,
	output reg [7:0] upper_q,
	output reg below_q,
	output reg above_q
);
	reg [7:0] level_q;
	wire take;
	wire is_below;
	wire is_above;

	assign take = sample_stb & measure_en; // [RQ2]
	assign is_below = sample_code < lower_q; // [RQ9]
	assign is_above = sample_code > upper_q; // [RQ10]
	// disabled domain reads zero
	assign level = measure_en ? level_q : `SVM_LEVEL_OFF; // [RQ11]

	// level and flags move in the same cycle; set beats clear
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 8'h00;
			below_q <= 1'b0;
			above_q <= 1'b0;
		end else begin
			if (take)
				level_q <= sample_code; // [RQ3] [RQ8] [RQ13]
			below_q <= (take & is_below) | (below_q & ~below_clr); // [RQ8] [RQ12]
			above_q <= (take & is_above) | (above_q & ~above_clr); // [RQ8] [RQ12]
		end
	end

	// thresholds, reset to full span
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lower_q <= `SVM_LOWER_RST; // [RQ6]
			upper_q <= `SVM_UPPER_RST; // [RQ6]
		end else begin
			if (lower_we)
				lower_q <= wdata;
			if (upper_we)
				upper_q <= wdata;
		end
	end
endmodule // svm_domain
`default_nettype wire

// >>> svm_supply_level_monitor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "svm_map.vh"
// ==========
// port checker, sees the top ports only
module svm_chk (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// converter and irq
	input wire logic conv_start,
	input wire logic [2:0] conv_channel,
	input wire logic conv_done,
	input wire logic [7:0] conv_code,
	input wire logic monitor_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// access phase of a transfer
	wire logic acc = psel && penable;
	chk_zero_wait: assert property (pready)
		else $error("pready low");
	chk_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start wider than one cycle");
	chk_slot_range: assert property (conv_start |->
		conv_channel < 3'h7 && $stable(conv_channel))
		else $error("bad slot at start");
	chk_bad_addr: assert property (acc && paddr == 12'h0FC |-> pslverr)
		else $error("no error on unmapped access");
	chk_page_free: assert property (
		acc && paddr == `SVM_OFF_PAGE |-> !pslverr)
		else $error("page select refused");
	chk_unmapped_zero: assert property (
		acc && !pwrite && paddr == 12'h0FC |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	// irq only moves on a sample or a register write
	chk_irq_cause: assert property ($rose(monitor_irq) |->
		$past(conv_done) || $past(conv_done, 2) || $past(acc && pwrite))
		else $error("irq rose without cause");
	chk_reset_quiet: assert property (
		$rose(rst_n) |-> !monitor_irq && !conv_start)
		else $error("activity right after reset");
	cover property (conv_done);
	cover property (monitor_irq);
	cover property (acc && pslverr);
endmodule // svm_chk
bind svm_supply_level_monitor svm_chk i_chk (.clock, .rst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
	.conv_start, .conv_channel, .conv_done, .conv_code, .monitor_irq);
`default_nettype wire

// >>> test_supply_voltage_monitor_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "svm_map.vh"
// ==========
// bench: apb access tasks and a converter stand-in
module test_supply_voltage_monitor_ctrl;
	logic clock, rst_n, psel, penable, pwrite, conv_done, err;
	logic [11:0] paddr, a;
	logic [31:0] pwdata, rdat;
	logic [7:0] code [0:7];
	logic [1:0] dly;
	wire logic pready, pslverr, conv_start, monitor_irq;
	wire logic [31:0] prdata;
	wire logic [2:0] conv_channel;
	wire logic [7:0] conv_code;
	int num_errors, checked;
	svm_supply_level_monitor #(.FRAME_CYC(50)) i_dut (.clock, .rst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .conv_start, .conv_channel, .conv_done, .conv_code,
		.monitor_irq);
	// code held steady per slot so every frame sees the same level
	assign conv_code = code[conv_channel];
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	// converter answers four cycles after each start
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			conv_done <= 0;
			dly <= 0;
		end else begin
			conv_done <= dly == 2'h1;
			dly <= conv_start ? 2'h3 : dly - 2'(dly != 0);
		end
	end
	task end_sim;
		if (num_errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one apb transfer; error and read data taken at the access edge
	task acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		err = pslverr;
		rdat = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task chk(input logic [11:0] ad, input logic [31:0] e);
		acc(0, ad, 0);
		cmp(rdat, e);
	endtask
	initial begin
		repeat (3000) @(posedge clock);
		num_errors++;
		end_sim;
	end
	// ==========
	// main sequence
	initial begin
		{psel, penable, pwrite, rst_n} = 0;
		{paddr, pwdata, num_errors, checked} = 0;
		code = '{8'h10, 8'h80, 8'hF0, 8'h40, 8'h50, 8'h60, 8'h70, 8'h00};
		repeat (5) @(posedge clock);
		rst_n <= 1;
		acc(0, `SVM_OFF_LOWER0, 0);
		cmp(err, 1);
		acc(1, `SVM_OFF_ENABLE, 32'h7F);
		cmp(err, 1);
		acc(1, `SVM_OFF_PAGE, 32'h01);
		chk(`SVM_OFF_ENABLE, 32'h00);
		cmp(err, 0);
		for (a = 0; a < 28; a += 4) begin
			chk(`SVM_OFF_LOWER0 + a, 32'h00);
			chk(`SVM_OFF_UPPER0 + a, 32'hFF);
		end
		acc(1, `SVM_OFF_LOWER0, 32'h20);
		acc(1, `SVM_OFF_UPPER0 + 12'h8, 32'hE0);
		acc(1, `SVM_OFF_IRQ_EN, 32'h01);
		acc(1, `SVM_OFF_ENABLE, 32'h7F);
		repeat (150) @(posedge clock);
		for (a = 0; a < 28; a += 4)
			chk(`SVM_OFF_LEVEL0 + a, code[a >> 2]);
		chk(`SVM_OFF_BELOW, 32'h01);
		chk(`SVM_OFF_ABOVE, 32'h04);
		cmp(monitor_irq, 1);
		acc(1, `SVM_OFF_ENABLE, 32'h7E);
		chk(`SVM_OFF_LEVEL0, 32'h00);
		cmp(monitor_irq, 0);
		acc(1, `SVM_OFF_ENABLE, 32'h00);
		repeat (100) @(posedge clock);
		acc(1, `SVM_OFF_BELOW, 32'h7E);
		chk(`SVM_OFF_BELOW, 32'h01);
		acc(1, `SVM_OFF_BELOW, 32'h01);
		chk(`SVM_OFF_BELOW, 32'h00);
		acc(1, `SVM_OFF_ABOVE, 32'h04);
		chk(`SVM_OFF_ABOVE, 32'h00);
		chk(12'h0FC, 32'h00);
		cmp(err, 1);
		end_sim;
	end
endmodule // test_supply_voltage_monitor_ctrl
`default_nettype wire
